// File: mrie_exec.sv
// Execute stage for the OR-with-file, move, literal load, no-op and return group.
// Assumes file_rd_data already holds the register addressed by the offered word,
// and stack_top_entry holds the current top of the return stack.
//
// Overview of operation
// - destination bit picks working or file register.
// - OR working with file, zero flag only.
// - move file to destination, one cycle, zero.
// - move back to same file tests only.
// - working to file, flags untouched, one cycle.
// - literal into working register, flags untouched.
// - return pops stack, loads PC, sets enable.
// - enable is bit seven of interrupt control.
// - return takes two instruction cycles.
`timescale 1ns/1ps
`default_nettype none
module mrie_exec (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Instruction offer
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  // File register space
  input wire logic [7:0] file_rd_data,
  output logic file_wr_en,
  output logic [6:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  // Working register and status
  output logic [7:0] work_reg,
  output logic zero_flag,
  // Return stack and program counter
  input wire logic [12:0] stack_top_entry,
  output logic stack_pop,
  output logic pc_load,
  output logic [12:0] pc_value,
  // Interrupt control register bit set
  output logic icr_set_en,
  output logic [7:0] icr_set_mask
);

  typedef enum logic {ST_RUN, ST_RET2} mrie_state_e;

  mrie_dec_if dif ();

  mrie_decoder u_dec (
    .d (dif.dec)
  );

  assign dif.word = instr_word;

  mrie_state_e state_q;
  mrie_state_e state_d;
  logic [7:0] w_q, w_d;
  logic z_q, z_d;
  logic wr_en_q, wr_en_d;
  logic [6:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;
  logic pop_q, pop_d;
  logic [12:0] pc_q, pc_d;
  logic irq_en_q, irq_en_d;
  logic [7:0] irq_mask_q, irq_mask_d;
  logic ready_q, ready_d;
  logic taken;
  logic [7:0] or_res;

  assign taken = instr_valid && ready_q;
  assign or_res = w_q | file_rd_data;

  always_comb begin
    state_d = state_q;
    w_d = w_q;
    z_d = z_q;
    wr_en_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    pop_d = 1'b0;
    pc_d = pc_q;
    irq_en_d = 1'b0;
    irq_mask_d = 8'h00;
    ready_d = 1'b1;
    case (state_q)
      ST_RUN: begin
        if (taken) begin
          case (dif.op)
            mrie_pkg::OP_OR: begin
              z_d = mrie_pkg::is_zero(or_res);
              if (dif.to_file) begin
                wr_en_d = 1'b1;
                wr_addr_d = dif.addr;
                wr_data_d = or_res;
              end else begin
                w_d = or_res;
              end
            end
            mrie_pkg::OP_MOV: begin
              z_d = mrie_pkg::is_zero(file_rd_data);
              // self move tests only.
              // A write back would retrigger side effects of special registers.
              if (!dif.to_file) begin
                w_d = file_rd_data;
              end
            end
            mrie_pkg::OP_STORE: begin
              wr_en_d = 1'b1;
              wr_addr_d = dif.addr;
              wr_data_d = w_q;
            end
            mrie_pkg::OP_LIT: begin
              w_d = dif.literal;
            end
            mrie_pkg::OP_RET: begin
              pop_d = 1'b1;
              pc_d = stack_top_entry;
              irq_en_d = 1'b1;
              irq_mask_d = mrie_pkg::IRQ_EN_MASK;
              ready_d = 1'b0;
              state_d = ST_RET2;
            end
            default: begin
            end
          endcase
        end
      end
      ST_RET2: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_RUN;
      w_q <= mrie_pkg::W_RST;
      z_q <= mrie_pkg::Z_RST;
      wr_en_q <= 1'b0;
      wr_addr_q <= mrie_pkg::ADDR_RST;
      wr_data_q <= mrie_pkg::W_RST;
      pop_q <= 1'b0;
      pc_q <= mrie_pkg::PC_RST;
      irq_en_q <= 1'b0;
      irq_mask_q <= 8'h00;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      w_q <= w_d;
      z_q <= z_d;
      wr_en_q <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      pop_q <= pop_d;
      pc_q <= pc_d;
      irq_en_q <= irq_en_d;
      irq_mask_q <= irq_mask_d;
      ready_q <= ready_d;
    end
  end

  assign instr_ready = ready_q;
  assign file_wr_en = wr_en_q;
  assign file_wr_addr = wr_addr_q;
  assign file_wr_data = wr_data_q;
  assign work_reg = w_q;
  assign zero_flag = z_q;
  assign stack_pop = pop_q;
  assign pc_load = pop_q;
  assign pc_value = pc_q;
  assign icr_set_en = irq_en_q;
  assign icr_set_mask = irq_mask_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  or_to_work_a:
    assert property (taken && dif.op == mrie_pkg::OP_OR && !dif.to_file
      |=> w_q == $past(or_res) && !wr_en_q)
    else $error("OR to working register wrong");

  or_to_file_a:
    assert property (taken && dif.op == mrie_pkg::OP_OR && dif.to_file
      |=> wr_en_q && wr_data_q == $past(or_res) && wr_addr_q == $past(dif.addr)
          && w_q == $past(w_q))
    else $error("OR to file register wrong");

  or_zero_a:
    assert property (taken && dif.op == mrie_pkg::OP_OR
      |=> z_q == ($past(or_res) == 8'h00))
    else $error("OR zero flag wrong");

  move_copy_a:
    assert property (taken && dif.op == mrie_pkg::OP_MOV && !dif.to_file
      |=> w_q == $past(file_rd_data) && z_q == (w_q == 8'h00) && ready_q)
    else $error("Move to working register wrong");

  move_test_a:
    assert property (taken && dif.op == mrie_pkg::OP_MOV && dif.to_file
      |=> !wr_en_q && $stable(w_q) && z_q == ($past(file_rd_data) == 8'h00))
    else $error("Self move test wrong");

  store_work_a:
    assert property (taken && dif.op == mrie_pkg::OP_STORE
      |=> wr_en_q && wr_data_q == $past(w_q) && $stable(z_q) && ready_q)
    else $error("Store of working register wrong");

  literal_load_a:
    assert property (taken && dif.op == mrie_pkg::OP_LIT
      |=> w_q == $past(instr_word[7:0]) && $stable(z_q) && !wr_en_q)
    else $error("Literal load wrong");

  return_pop_a:
    assert property (taken && dif.op == mrie_pkg::OP_RET
      |=> pop_q && pc_q == $past(stack_top_entry) && irq_en_q && $stable(z_q)
          ##1 !pop_q && !irq_en_q)
    else $error("Return pop wrong");

  irq_bit_a:
    assert property (irq_en_q |-> irq_mask_q == 8'h80)
    else $error("Enable set on wrong bit");

  return_two_a:
    assert property (taken && dif.op == mrie_pkg::OP_RET |=> !ready_q ##1 ready_q)
    else $error("Return not two cycles");

  zero_only_a:
    assert property (taken && (dif.op == mrie_pkg::OP_NOP || dif.op == mrie_pkg::OP_RET)
      |=> $stable(z_q) && $stable(w_q))
    else $error("Flag or working register changed unexpectedly");

  cov_or_file_c: cover property (taken && dif.op == mrie_pkg::OP_OR && dif.to_file);
  cov_move_test_c: cover property (taken && dif.op == mrie_pkg::OP_MOV && dif.to_file);
  cov_return_c: cover property (taken && dif.op == mrie_pkg::OP_RET ##2 taken);
  cov_zero_c: cover property (!z_q ##1 z_q);

endmodule : mrie_exec
`default_nettype wire

// File: mrie_pkg.sv
// Constants, opcode encodings and helpers for the move/or/return execute block.
// Assumes a 14-bit instruction word and an 8-bit data path with 7-bit file addresses.
package mrie_pkg;

  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;

  // Field positions inside the instruction word and the interrupt control register.
  localparam int DEST_BIT = 7;
  localparam int IRQ_EN_BIT = 7;

  // Opcode masks and match values.
  localparam logic [13:0] FILE_OP_MASK = 14'h3f00;
  localparam logic [13:0] OR_MATCH = 14'h0400;
  localparam logic [13:0] MOV_MATCH = 14'h0800;
  localparam logic [13:0] STORE_MASK = 14'h3f80;
  localparam logic [13:0] STORE_MATCH = 14'h0080;
  localparam logic [13:0] LIT_MASK = 14'h3c00;
  localparam logic [13:0] LIT_MATCH = 14'h3000;
  localparam logic [13:0] RET_MASK = 14'h3fff;
  localparam logic [13:0] RET_MATCH = 14'h0009;
  localparam logic [13:0] NOP_MASK = 14'h3f9f;
  localparam logic [13:0] NOP_MATCH = 14'h0000;

  // Values after reset, and the interrupt enable mask.
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic Z_RST = 1'b0;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [7:0] IRQ_EN_MASK = 8'h80;

  // Cycle counts.
  localparam int ONE_CYCLE = 1;
  localparam int RET_CYCLES = 2;

  typedef enum logic [2:0] {
    OP_NOP, OP_OR, OP_MOV, OP_STORE, OP_LIT, OP_RET, OP_OTHER
  } mrie_op_e;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

endpackage : mrie_pkg

// File: mrie_dec_if.sv
// Decoded instruction fields passed from the decoder to the execute stage.
// Assumes the execute stage drives the raw word and reads back the fields.
`timescale 1ns/1ps
`default_nettype none
interface mrie_dec_if;
  logic [13:0] word;
  mrie_pkg::mrie_op_e op;
  logic to_file;
  logic [6:0] addr;
  logic [7:0] literal;

  modport dec (input word, output op, output to_file, output addr, output literal);
  modport exe (output word, input op, input to_file, input addr, input literal);
endinterface : mrie_dec_if
`default_nettype wire

// File: mrie_decoder.sv
// Combinational decoder for the move/or/return instruction group.
// Assumes a 14-bit word; encodings outside the group decode as OP_OTHER.
`timescale 1ns/1ps
`default_nettype none
module mrie_decoder (
  // Decoded fields
  mrie_dec_if.dec d
);

  always_comb begin
    d.to_file = d.word[mrie_pkg::DEST_BIT];
    d.addr = d.word[6:0];
    d.literal = d.word[7:0];
    if ((d.word & mrie_pkg::RET_MASK) == mrie_pkg::RET_MATCH) begin
      d.op = mrie_pkg::OP_RET;
    end else if ((d.word & mrie_pkg::STORE_MASK) == mrie_pkg::STORE_MATCH) begin
      d.op = mrie_pkg::OP_STORE;
    end else if ((d.word & mrie_pkg::NOP_MASK) == mrie_pkg::NOP_MATCH) begin
      d.op = mrie_pkg::OP_NOP;
    end else if ((d.word & mrie_pkg::FILE_OP_MASK) == mrie_pkg::OR_MATCH) begin
      d.op = mrie_pkg::OP_OR;
    end else if ((d.word & mrie_pkg::FILE_OP_MASK) == mrie_pkg::MOV_MATCH) begin
      d.op = mrie_pkg::OP_MOV;
    end else if ((d.word & mrie_pkg::LIT_MASK) == mrie_pkg::LIT_MATCH) begin
      // Upper literal bits are don't-care; zeros are expected there.
      d.op = mrie_pkg::OP_LIT;
    end else begin
      d.op = mrie_pkg::OP_OTHER;
    end
  end

endmodule : mrie_decoder
`default_nettype wire

// File: tb.sv
// Self-checking bench for the move/or/return execute block.
// Assumes the block stands alone; file read data and stack top are driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] file_rd_data = 8'h00;
  logic [12:0] stack_top_entry = 13'h0000;
  logic instr_ready, file_wr_en, zero_flag, stack_pop, pc_load, icr_set_en;
  logic [6:0] file_wr_addr;
  logic [7:0] file_wr_data, work_reg, icr_set_mask;
  logic [12:0] pc_value;
  logic [13:0] odd_words [3] = '{14'h0000, 14'h0060, 14'h3fff};
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  always #10 clock = ~clock;

  mrie_exec i_dut (
    .clock(clock), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .work_reg(work_reg),
    .zero_flag(zero_flag), .stack_top_entry(stack_top_entry), .stack_pop(stack_pop),
    .pc_load(pc_load), .pc_value(pc_value), .icr_set_en(icr_set_en),
    .icr_set_mask(icr_set_mask)
  );

  task automatic end_sim();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // The whole run needs well under a hundred cycles.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      end_sim();
    end
  end

  function automatic logic [13:0] fop(input logic [13:0] b, input logic d, input logic [6:0] a);
    fop = b | {6'h00, d, a};
  endfunction : fop

  function automatic logic [13:0] lit(input logic [7:0] k, input logic [1:0] dc);
    lit = 14'h3000 | {4'h0, dc, k};
  endfunction : lit

  // Called at a falling edge; valid stays up so words can follow back to back.
  task automatic issue(input logic [13:0] w, input logic [7:0] f);
    instr_valid = 1'b1;
    instr_word = w;
    file_rd_data = f;
    @(posedge clock);
    @(negedge clock);
  endtask : issue

  task automatic idle();
    instr_valid = 1'b0;
    file_rd_data = ~file_rd_data;
    @(negedge clock);
  endtask : idle

  task automatic expect_res(input logic wen, input logic [6:0] wa, input logic [7:0] wd,
                            input logic [7:0] w, input logic z);
    `CHK(file_wr_en, wen)
    if (wen) begin
      `CHK(file_wr_addr, wa)
      `CHK(file_wr_data, wd)
    end
    `CHK(work_reg, w)
    `CHK(zero_flag, z)
    `CHK({stack_pop, pc_load, icr_set_en, instr_ready}, 4'h1)
    `CHK(icr_set_mask, 8'h00)
  endtask : expect_res

  task automatic t_reset();
    `CHK({instr_ready, file_wr_en, stack_pop, pc_load, icr_set_en}, 5'h00)
    `CHK({icr_set_mask, pc_value}, 21'h00000)
    `CHK({zero_flag, work_reg, file_wr_addr, file_wr_data}, 24'h000000)
    $display("test reset done");
  endtask : t_reset

  task automatic t_literal();
    issue(lit(8'h00, 2'b00), 8'h00);
    expect_res(1'b0, 7'h00, 8'h00, 8'h00, 1'b0);
    issue(lit(8'h5a, 2'b00), 8'h00);
    expect_res(1'b0, 7'h00, 8'h00, 8'h5a, 1'b0);
    issue(lit(8'hff, 2'b00), 8'h00);
    expect_res(1'b0, 7'h00, 8'h00, 8'hff, 1'b0);
    $display("test literal done");
  endtask : t_literal

  task automatic t_or();
    issue(lit(8'h00, 2'b00), 8'h55);
    issue(fop(mrie_pkg::OR_MATCH, 1'b0, 7'h7f), 8'h00);
    expect_res(1'b0, 7'h00, 8'h00, 8'h00, 1'b1);
    issue(lit(8'h0c, 2'b00), 8'h00);
    expect_res(1'b0, 7'h00, 8'h00, 8'h0c, 1'b1);
    issue(fop(mrie_pkg::OR_MATCH, 1'b1, 7'h25), 8'h30);
    expect_res(1'b1, 7'h25, 8'h3c, 8'h0c, 1'b0);
    issue(fop(mrie_pkg::OR_MATCH, 1'b0, 7'h00), 8'h81);
    expect_res(1'b0, 7'h00, 8'h00, 8'h8d, 1'b0);
    idle();
    $display("test or done");
  endtask : t_or

  task automatic t_move();
    issue(fop(mrie_pkg::MOV_MATCH, 1'b0, 7'h10), 8'h00);
    expect_res(1'b0, 7'h00, 8'h00, 8'h00, 1'b1);
    issue(fop(mrie_pkg::MOV_MATCH, 1'b0, 7'h11), 8'h81);
    expect_res(1'b0, 7'h00, 8'h00, 8'h81, 1'b0);
    issue(fop(mrie_pkg::MOV_MATCH, 1'b1, 7'h12), 8'h00);
    expect_res(1'b0, 7'h00, 8'h00, 8'h81, 1'b1);
    issue(fop(mrie_pkg::MOV_MATCH, 1'b1, 7'h13), 8'h42);
    expect_res(1'b0, 7'h00, 8'h00, 8'h81, 1'b0);
    $display("test move done");
  endtask : t_move

  task automatic t_store();
    issue(fop(mrie_pkg::MOV_MATCH, 1'b1, 7'h14), 8'h00);
    issue(mrie_pkg::STORE_MATCH | 14'h007f, 8'h00);
    expect_res(1'b1, 7'h7f, 8'h81, 8'h81, 1'b1);
    issue(mrie_pkg::STORE_MATCH | 14'h0000, 8'hff);
    expect_res(1'b1, 7'h00, 8'h81, 8'h81, 1'b1);
    idle();
    `CHK(file_wr_en, 1'b0)
    $display("test store done");
  endtask : t_store

  task automatic t_return();
    stack_top_entry = 13'h1abc;
    issue(14'h0009, 8'h00);
    `CHK({stack_pop, pc_load, icr_set_en, instr_ready}, 4'b1110)
    `CHK(pc_value, 13'h1abc)
    `CHK(icr_set_mask, 8'h80)
    `CHK({zero_flag, work_reg}, 9'h181)
    // A word offered in the second return cycle must wait.
    stack_top_entry = 13'h0543;
    issue(lit(8'h11, 2'b00), 8'h00);
    expect_res(1'b0, 7'h00, 8'h00, 8'h81, 1'b1);
    `CHK(pc_value, 13'h1abc)
    issue(lit(8'h11, 2'b00), 8'h00);
    expect_res(1'b0, 7'h00, 8'h00, 8'h11, 1'b1);
    foreach (odd_words[i]) begin
      issue(odd_words[i], 8'h00);
      expect_res(1'b0, 7'h00, 8'h00, 8'h11, 1'b1);
    end
    idle();
    $display("test return done");
  endtask : t_return

  initial begin
    repeat (6) @(negedge clock);
    t_reset();
    rst = 1'b0;
    repeat (2) @(negedge clock);
    t_literal();
    t_or();
    t_move();
    t_store();
    t_return();
    end_sim();
  end
endmodule : tb
`default_nettype wire
